/* File: agi_gain_access.sv */
// converter configuration, result high/low registers and the indirect gain path
// assumes strobes and data are synchronous to ref_clk and last one cycle
`timescale 1ns/10ps
`default_nettype none

module agi_gain_access (
  input  wire logic        ref_clk,        // core clock, 125 MHz
  input  wire logic        rst_n,          // synchronous reset, active low
  input  wire logic        cfgWrEn,        // write strobe, converter config reg
  input  wire logic        resHighWrEn,    // write strobe, result high reg
  input  wire logic        resLowWrEn,     // write strobe, result low reg
  input  wire logic [7:0]  wrData,         // write data for all strobes
  input  wire logic        convDone,       // conversion finished, one-cycle pulse
  input  wire logic [15:0] convResult,     // conversion result, valid with convDone
  output logic      [7:0]  cfgRdData,      // converter config reg contents
  output logic      [7:0]  resHighRdData,  // result high reg contents
  output logic      [7:0]  resLowRdData,   // result low reg contents
  output logic             gainAccessEnable, // gain access enable bit
  output logic      [7:0]  gainHigh,       // gain value high register
  output logic      [7:0]  gainLow,        // gain value low register
  output logic             gainAddFlag     // gain-add control flag
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0] cfg_reg;
  logic [7:0] resHigh_reg;
  logic [7:0] resLow_reg;
  logic [7:0] gainAddr_reg;
  logic [7:0] gainHigh_reg;
  logic [7:0] gainLow_reg;
  logic       gain_add_flag_reg;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire logic       accessOn;
  wire logic       addrWr;
  wire logic       dataWr;
  wire logic       selHigh;
  wire logic       selLow;
  wire logic       selAdd;
  wire logic       normHighWr;
  wire logic       normLowWr;
  wire logic [7:0] resHigh_next;
  wire logic [7:0] resLow_next;

  assign accessOn   = cfg_reg[agi_pkg::CFG_EN_BIT];
  assign addrWr     = accessOn & resHighWrEn;
  assign dataWr     = accessOn & resLowWrEn;
  assign selHigh    = dataWr & (gainAddr_reg == agi_pkg::ADDR_GAIN_HIGH);
  assign selLow     = dataWr & (gainAddr_reg == agi_pkg::ADDR_GAIN_LOW);
  assign selAdd     = dataWr & (gainAddr_reg == agi_pkg::ADDR_GAIN_ADD);
  assign normHighWr = ~accessOn & resHighWrEn;
  assign normLowWr  = ~accessOn & resLowWrEn;
  // software write beats a finishing conversion in the same cycle
  assign resHigh_next = normHighWr ? wrData :
                        convDone   ? convResult[agi_pkg::RES_HIGH_MSB:agi_pkg::RES_HIGH_LSB] :
                        resHigh_reg;
  assign resLow_next  = normLowWr  ? wrData :
                        convDone   ? convResult[agi_pkg::RES_LOW_MSB:agi_pkg::RES_LOW_LSB] :
                        resLow_reg;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cfg_reg     <= agi_pkg::RST_CFG;
      resHigh_reg <= agi_pkg::RST_RESULT;
      resLow_reg  <= agi_pkg::RST_RESULT;
    end else begin
      if (cfgWrEn) begin
        cfg_reg <= wrData;
      end
      resHigh_reg <= resHigh_next;
      resLow_reg  <= resLow_next;
    end
  end

  // gain registers never feed any read port: write-only by construction
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      gainAddr_reg <= agi_pkg::RST_ADDR;
      gainHigh_reg <= agi_pkg::RST_GAIN_HIGH;
      gainLow_reg  <= agi_pkg::RST_GAIN_LOW;
      gain_add_flag_reg  <= agi_pkg::RST_ADD_FLAG;
    end else begin
      if (addrWr) begin
        gainAddr_reg <= wrData;
      end
      if (selHigh) begin
        gainHigh_reg <= wrData;
      end
      if (selLow) begin
        gainLow_reg <= wrData;
      end
      if (selAdd) begin
        gain_add_flag_reg <= wrData[agi_pkg::ADD_FLAG_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs, straight from flip-flops
  // ---------------------------------------------------------------
  assign cfgRdData        = cfg_reg;
  assign resHighRdData    = resHigh_reg;
  assign resLowRdData     = resLow_reg;
  assign gainAccessEnable = cfg_reg[agi_pkg::CFG_EN_BIT];
  assign gainHigh         = gainHigh_reg;
  assign gainLow          = gainLow_reg;
  assign gainAddFlag      = gain_add_flag_reg;

  // full 12-bit gain as the converter core uses it
  wire logic [agi_pkg::GAIN_W-1:0] gainValue;
  assign gainValue = {gainHigh_reg,
                      gainLow_reg[agi_pkg::LOW_NIB_MSB:agi_pkg::LOW_NIB_LSB]};

  // ---------------------------------------------------------------
  // assertion helpers
  // ---------------------------------------------------------------
  // a low write to any other address must fall on the floor
  wire logic addrKnown;
  assign addrKnown = (gainAddr_reg == agi_pkg::ADDR_GAIN_HIGH) |
                     (gainAddr_reg == agi_pkg::ADDR_GAIN_LOW)  |
                     (gainAddr_reg == agi_pkg::ADDR_GAIN_ADD);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_cfg_enable_bit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cfgWrEn |=> gainAccessEnable == $past(wrData[agi_pkg::CFG_EN_BIT]))
    else $error("enable bit does not follow config write");

  a_addr_capture: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (gainAccessEnable && resHighWrEn) |=> gainAddr_reg == $past(wrData))
    else $error("indirect address not captured");

  a_gain_high_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (gainAccessEnable && resLowWrEn && gainAddr_reg == agi_pkg::ADDR_GAIN_HIGH)
      |=> gainHigh == $past(wrData) && $stable(gainLow))
    else $error("gain high not written at its address");

  a_gain_low_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (gainAccessEnable && resLowWrEn && gainAddr_reg == agi_pkg::ADDR_GAIN_LOW)
      |=> gainLow == $past(wrData) && $stable(gainHigh))
    else $error("gain low not written at its address");

  a_add_flag_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (gainAccessEnable && resLowWrEn && gainAddr_reg == agi_pkg::ADDR_GAIN_ADD)
      |=> gainAddFlag == $past(wrData[agi_pkg::ADD_FLAG_BIT]))
    else $error("gain-add flag not written");

  a_no_readback: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (gainAccessEnable && resLowWrEn && !convDone) |=> $stable(resLowRdData))
    else $error("gain data leaked onto result low read");

  a_value_form: assert property (@(posedge ref_clk) disable iff (!rst_n)
    gainValue == {gainHigh, gainLow[agi_pkg::LOW_NIB_MSB:agi_pkg::LOW_NIB_LSB]})
    else $error("gain value misassembled");

  a_normal_mode_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!gainAccessEnable && resLowWrEn)
      |=> resLowRdData == $past(wrData) && $stable(gainHigh) && $stable(gainLow)
          && $stable(gainAddFlag))
    else $error("normal result write misbehaved");

  a_cfg_readback: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cfgWrEn |=> cfgRdData == $past(wrData))
    else $error("config register does not read back its write");

  a_enable_holds: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !cfgWrEn |=> $stable(gainAccessEnable))
    else $error("enable bit moved without a config write");

  a_addr_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(gainAccessEnable && resHighWrEn) |=> $stable(gainAddr_reg))
    else $error("indirect address moved without an address write");

  a_result_high_guard: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (gainAccessEnable && resHighWrEn && !convDone) |=> $stable(resHighRdData))
    else $error("address write leaked into result high");

  a_unknown_addr_drop: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (gainAccessEnable && resLowWrEn && !addrKnown)
      |=> $stable(gainHigh) && $stable(gainLow) && $stable(gainAddFlag))
    else $error("low write to an unused address changed a gain register");

  a_high_byte_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (gainAccessEnable && resLowWrEn && gainAddr_reg == agi_pkg::ADDR_GAIN_HIGH)
      |=> gainValue == {$past(wrData),
                        $past(gainLow[agi_pkg::LOW_NIB_MSB:agi_pkg::LOW_NIB_LSB])})
    else $error("gain high byte misplaced in the gain value");

  a_low_nibble_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (gainAccessEnable && resLowWrEn && gainAddr_reg == agi_pkg::ADDR_GAIN_LOW)
      |=> gainValue == {$past(gainHigh),
                        $past(wrData[agi_pkg::LOW_NIB_MSB:agi_pkg::LOW_NIB_LSB])})
    else $error("gain low nibble misplaced in the gain value");

  a_add_flag_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(gainAccessEnable && resLowWrEn && gainAddr_reg == agi_pkg::ADDR_GAIN_ADD)
      |=> $stable(gainAddFlag))
    else $error("gain-add flag moved without its write");

  a_disabled_gain_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!gainAccessEnable && (resHighWrEn || resLowWrEn))
      |=> $stable(gainHigh) && $stable(gainLow) && $stable(gainAddFlag))
    else $error("result write with access off changed a gain register");

  a_conv_load_high: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (convDone && !(resHighWrEn && !gainAccessEnable))
      |=> resHighRdData == $past(convResult[agi_pkg::RES_HIGH_MSB:agi_pkg::RES_HIGH_LSB]))
    else $error("conversion did not load result high");

  a_conv_load_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (convDone && !(resLowWrEn && !gainAccessEnable))
      |=> resLowRdData == $past(convResult[agi_pkg::RES_LOW_MSB:agi_pkg::RES_LOW_LSB]))
    else $error("conversion did not load result low");

  a_write_beats_conv: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!gainAccessEnable && resHighWrEn && convDone) |=> resHighRdData == $past(wrData))
    else $error("conversion overrode a software result write");

endmodule

`default_nettype wire

/* File: agi_pkg.sv */
// constants for the converter gain indirect-access block
// assumes one core clock and single-cycle special function register write strobes
//
// What this block does
// - set enable bit 0 of config routes result high/low writes to gains
// - while enabled, high writes pick an address, low writes carry data
// - gain registers are write-only; no read path returns their contents
// - indirect address 0x04 is gain high, 0x07 gain low, 0x08 additional
// - gain value is high byte above the upper nibble of the low register
`default_nettype none
package agi_pkg;
  // ---------------------------------------------------------------
  // field positions and widths
  // ---------------------------------------------------------------
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned GAIN_W        = 12;
  localparam int unsigned CFG_EN_BIT    = 0;
  localparam int unsigned ADD_FLAG_BIT  = 0;
  localparam int unsigned LOW_NIB_MSB   = 7;
  localparam int unsigned LOW_NIB_LSB   = 4;
  localparam int unsigned RES_HIGH_MSB  = 15;
  localparam int unsigned RES_HIGH_LSB  = 8;
  localparam int unsigned RES_LOW_MSB   = 7;
  localparam int unsigned RES_LOW_LSB   = 0;

  // ---------------------------------------------------------------
  // indirect addresses of the gain registers
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_GAIN_HIGH = 8'h04;
  localparam logic [7:0] ADDR_GAIN_LOW  = 8'h07;
  localparam logic [7:0] ADDR_GAIN_ADD  = 8'h08;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_CFG        = 8'h00;
  localparam logic [7:0] RST_RESULT     = 8'h00;
  localparam logic [7:0] RST_ADDR       = 8'h00;
  localparam logic [7:0] RST_GAIN_HIGH  = 8'h00;
  localparam logic [7:0] RST_GAIN_LOW   = 8'h00;
  localparam logic       RST_ADD_FLAG   = 1'b0;
endpackage
`default_nettype wire

/* File: tb_top.sv */
// self-checking testbench for the converter gain indirect-access block
// assumes agi_pkg and agi_gain_access are compiled first; bench drives all input ports
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        ref_clk;
  logic        rst_n;
  logic        cfgWrEn;
  logic        resHighWrEn;
  logic        resLowWrEn;
  logic        convDone;
  logic        gainAccessEnable;
  logic        gainAddFlag;
  logic [7:0]  wrData;
  logic [7:0]  cfgRdData;
  logic [7:0]  resHighRdData;
  logic [7:0]  resLowRdData;
  logic [7:0]  gainHigh;
  logic [7:0]  gainLow;
  logic [15:0] convResult;
  int          nErrors = 0;
  int          cmpCount = 0;

  agi_gain_access agi_gain_access_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .cfgWrEn(cfgWrEn), .resHighWrEn(resHighWrEn),
    .resLowWrEn(resLowWrEn), .wrData(wrData), .convDone(convDone),
    .convResult(convResult), .cfgRdData(cfgRdData), .resHighRdData(resHighRdData),
    .resLowRdData(resLowRdData), .gainAccessEnable(gainAccessEnable),
    .gainHigh(gainHigh), .gainLow(gainLow), .gainAddFlag(gainAddFlag));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // ---------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      nErrors++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // sel: 0 config, 1 high, 2 low, 3 high and low, 4 conversion, 5 high with conversion
  task automatic wr(input int sel, input logic [15:0] d);
    @(posedge ref_clk);
    #1;
    wrData = d[7:0];
    convResult = d;
    cfgWrEn = (sel == 0);
    resHighWrEn = (sel == 1 || sel == 3 || sel == 5);
    resLowWrEn = (sel == 2 || sel == 3);
    convDone = (sel == 4 || sel == 5);
    @(posedge ref_clk);
    #1;
    {cfgWrEn, resHighWrEn, resLowWrEn, convDone} = 4'h0;
  endtask

  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", cmpCount, nErrors);
    if (nErrors == 0 && cmpCount > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    {rst_n, cfgWrEn, resHighWrEn, resLowWrEn, convDone} = 5'h00;
    wrData = 8'h00;
    convResult = 16'h0000;
    repeat (16) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    chk({cfgRdData, resHighRdData}, 16'h0000);
    chk({gainHigh, gainLow}, 16'h0000);
    wr(1, 16'h0012);
    wr(2, 16'h0034);
    chk({resHighRdData, resLowRdData}, 16'h1234);
    chk({gainHigh, gainLow}, 16'h0000);
    wr(4, 16'hABCD);
    chk({resHighRdData, resLowRdData}, 16'hABCD);
    wr(0, 16'h0001);
    chk({cfgRdData, 7'h00, gainAccessEnable}, 16'h0101);
    wr(1, 16'h0004);
    wr(2, 16'h006C);
    chk({8'h00, gainHigh}, 16'h006C);
    chk({resHighRdData, resLowRdData}, 16'hABCD);
    wr(1, 16'h0007);
    wr(2, 16'h00A0);
    chk({4'h0, gainHigh, gainLow[7:4]}, 16'h06CA);
    wr(1, 16'h0008);
    wr(2, 16'h0001);
    chk({15'h0000, gainAddFlag}, 16'h0001);
    wr(1, 16'h0005);
    wr(2, 16'h00FF);
    chk({gainHigh, gainLow}, 16'h6CA0);
    chk({15'h0000, gainAddFlag}, 16'h0001);
    // same-cycle pair: the low write still lands on the old address
    wr(1, 16'h0008);
    wr(3, 16'h0000);
    chk({15'h0000, gainAddFlag}, 16'h0000);
    wr(0, 16'h0000);
    chk({cfgRdData, 7'h00, gainAccessEnable}, 16'h0000);
    wr(1, 16'h0004);
    wr(2, 16'h0055);
    chk({gainHigh, gainLow}, 16'h6CA0);
    chk({resHighRdData, resLowRdData}, 16'h0455);
    wr(5, 16'h1299);
    chk({resHighRdData, resLowRdData}, 16'h9999);
    end_sim();
  end

  // hang guard, far beyond the roughly 52 cycles the sequence needs
  initial begin
    #20000;
    nErrors++;
    end_sim();
  end
endmodule
`default_nettype wire
